/* File: crc16_checksum_pkg.sv */
// Package for the 16-bit checksum unit: offsets, reset values,
// polynomials, bus carriers and the unit's state record.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package crc16_checksum_pkg;

    // Bus widths.
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;

    // Register byte offsets, one aligned word each.
    localparam logic [7:0] OFFSET_BYTE_INPUT   = 8'h00;
    localparam logic [7:0] OFFSET_SUM_LOW      = 8'h04;
    localparam logic [7:0] OFFSET_SUM_HIGH     = 8'h08;
    localparam logic [7:0] OFFSET_POLYNOMIAL_SELECT_CONTROL = 8'h0C;
    localparam logic [7:0] WORD_ADDR_MASK      = 8'hFC;

    // Field position of the polynomial select bit in the control word.
    localparam int POLYNOMIAL_SELECT_SELECT_BIT = 0;

    // Values after reset.
    localparam logic [7:0] RESET_BYTE_INPUT = 8'h00;
    localparam logic [7:0] RESET_SUM_LOW    = 8'h00;
    localparam logic [7:0] RESET_SUM_HIGH   = 8'h00;
    localparam logic       RESET_POLYNOMIAL_SELECT_SEL   = 1'b0;

    // Polynomial selection and feedback terms.
    localparam logic        POLYNOMIAL_SELECT_SELECT_CCITT = 1'b0;
    localparam logic        POLYNOMIAL_SELECT_SELECT_CRC16 = 1'b1;
    localparam logic [15:0] FEEDBACK_CCITT    = 16'h1021;
    localparam logic [15:0] FEEDBACK_CRC16    = 16'h8005;

    // Number of shift steps folded per input byte.
    localparam int BITS_PER_BYTE = 8;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write request from the master.
    typedef struct packed {
        logic                    awvalid;
        logic [ADDR_WIDTH-1:0]   awaddr;
        logic                    wvalid;
        logic [DATA_WIDTH-1:0]   wdata;
        logic [DATA_WIDTH/8-1:0] wstrb;
        logic                    bready;
    } write_req_type;

    // Write answer from the unit.
    typedef struct packed {
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
    } write_rsp_type;

    // Read request from the master.
    typedef struct packed {
        logic                  arvalid;
        logic [ADDR_WIDTH-1:0] araddr;
        logic                  rready;
    } read_req_type;

    // Read answer from the unit.
    typedef struct packed {
        logic                  arready;
        logic                  rvalid;
        logic [DATA_WIDTH-1:0] rdata;
        logic [1:0]            rresp;
    } read_rsp_type;

    // Whole state of the unit.
    typedef struct packed {
        logic                  awHeld;
        logic [ADDR_WIDTH-1:0] awAddr;
        logic                  wHeld;
        logic [7:0]            wByte;
        logic                  wLane0;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [DATA_WIDTH-1:0] rdata;
        logic [1:0]            rresp;
        logic [7:0]            byteInput;
        logic [7:0]            sumHigh;
        logic [7:0]            sumLow;
        logic                  polySelect;
    } unit_state_type;

    // State after reset; the bus is idle and all registers are cleared.
    localparam unit_state_type UNIT_STATE_RESET = '{
        byteInput:  RESET_BYTE_INPUT,
        sumHigh:    RESET_SUM_HIGH,
        sumLow:     RESET_SUM_LOW,
        polySelect: RESET_POLYNOMIAL_SELECT_SEL,
        default:    '0
    };

endpackage

/* File: crc_bit_step.sv */
// One shift step of a 16-bit checksum: shift left, insert zero, and
// fold in the feedback term when the bit shifted out was set.
// Purely combinational; the caller chains as many steps as it needs.
`timescale 1ns/10ps
module crc_bit_step #(
    parameter int WIDTH = 16                 // Checksum width.
) (
    input  wire logic [WIDTH-1:0] valueIn,   // Value before the step.
    input  wire logic [WIDTH-1:0] feedback,  // Feedback term to fold in.
    output logic      [WIDTH-1:0] valueOut   // Value after the step.
);

    // The bit leaving the top decides whether the feedback is applied.
    always_comb begin
        valueOut = {valueIn[WIDTH-2:0], 1'b0};
        if (valueIn[WIDTH-1]) begin
            valueOut = valueOut ^ feedback;
        end
    end

endmodule

/* File: crc_byte_fold.sv */
// Folds one input byte into the stored 16-bit checksum in one pass:
// byte into the high half, then eight chained shift steps.
// Purely combinational; the register that holds the sum sits outside.
`timescale 1ns/10ps
module crc_byte_fold (
    input  wire logic [15:0] sumIn,       // Stored checksum.
    input  wire logic [7:0]  dataByte,    // Byte to fold in.
    input  wire logic        polySelect,  // Zero picks CCITT, one CRC-16.
    output logic      [15:0] sumOut       // Checksum after the byte.
);

    logic [15:0] feedback;                                         // Chosen term.
    logic [15:0] chain [0:crc16_checksum_pkg::BITS_PER_BYTE];      // Step values.

    // Only the two fixed terms exist; nothing else can be programmed.
    // two fixed terms
    assign feedback = (polySelect == crc16_checksum_pkg::POLYNOMIAL_SELECT_SELECT_CRC16)
                      ? crc16_checksum_pkg::FEEDBACK_CRC16
                      : crc16_checksum_pkg::FEEDBACK_CCITT;

    // The byte meets the high half before any shifting starts.
    // byte into high half
    assign chain[0] = sumIn ^ {dataByte, 8'h00};

    // Eight identical steps, one per input bit.
    for (genvar i = 0; i < crc16_checksum_pkg::BITS_PER_BYTE; i++) begin : gStep
        crc_bit_step #(
            .WIDTH    (16)
        ) uStep (
            .valueIn  (chain[i]),
            .feedback (feedback),
            .valueOut (chain[i+1])
        );
    end

    assign sumOut = chain[crc16_checksum_pkg::BITS_PER_BYTE];

endmodule

/* File: crc16_checksum_unit.sv */
// Register-mapped 16-bit checksum unit behind an AXI4-Lite slave port.
// Assumes one clock, an AXI4-Lite master with at most one write and one
// read under way, and software that clears the sum before a new run.
// A sum write and a byte fold never meet in one cycle, since one write
// is carried at a time; the logic still lets the sum write win.
//
// Operation
// - Eight-bit input register takes each byte.
// - Bytes enter only through the input register.
// - Stored sum is the starting point.
// - High register holds sum bits 15..8, read/write.
// - Low register holds sum bits 7..0, read/write.
// - Control bit 0 picks CCITT or CRC-16.
// - Only those two polynomials are supported.
// - Control bits 7..1 read back as zero.
// - Input write updates the sum in one cycle.
// - XOR byte high, eight shifts, conditional feedback.
`timescale 1ns/10ps
module crc16_checksum_unit (
    input  wire logic                               clock,    // System clock.
    input  wire logic                               rst,      // Async reset.
    input  wire crc16_checksum_pkg::write_req_type  writeReq, // Write request.
    output crc16_checksum_pkg::write_rsp_type       writeRsp, // Write answer.
    input  wire crc16_checksum_pkg::read_req_type   readReq,  // Read request.
    output crc16_checksum_pkg::read_rsp_type        readRsp   // Read answer.
);

    crc16_checksum_pkg::unit_state_type s_q;     // Registered state.
    crc16_checksum_pkg::unit_state_type s_d;     // Next state.

    logic        doWrite;                        // Address and data both held.
    logic        writeMapped;                    // Held address hits a register.
    logic        inWrite;                        // Write to the input register.
    logic        lowWrite;                       // Write to the low sum.
    logic        highWrite;                      // Write to the high sum.
    logic        ctrlWrite;                      // Write to the control word.
    logic        readTaken;                      // Read address handshake.
    logic [15:0] sumNow;                         // Stored checksum.
    logic [15:0] foldOut;                        // Sum after folding the byte.

    // Returns the word address part of a byte address.
    function automatic logic [7:0] wordOf(input logic [7:0] addr);
        return addr & crc16_checksum_pkg::WORD_ADDR_MASK;
    endfunction

    // True when an address selects one of the four registers.
    function automatic logic isMapped(input logic [7:0] addr);
        logic [7:0] w;
        w = wordOf(addr);
        return (w == crc16_checksum_pkg::OFFSET_BYTE_INPUT) ||
               (w == crc16_checksum_pkg::OFFSET_SUM_LOW) ||
               (w == crc16_checksum_pkg::OFFSET_SUM_HIGH) ||
               (w == crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL);
    endfunction

    // Builds the read word for an address from the present state.
    function automatic logic [31:0] readWord(
        input logic [7:0]                         addr,
        input crc16_checksum_pkg::unit_state_type st
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        case (wordOf(addr))
            crc16_checksum_pkg::OFFSET_BYTE_INPUT: begin
                word[7:0] = st.byteInput;
            end
            crc16_checksum_pkg::OFFSET_SUM_LOW: begin
                word[7:0] = st.sumLow;
            end
            crc16_checksum_pkg::OFFSET_SUM_HIGH: begin
                word[7:0] = st.sumHigh;
            end
            crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL: begin
                word[crc16_checksum_pkg::POLYNOMIAL_SELECT_SELECT_BIT] = st.polySelect;
            end
            default: begin
                word = 32'h0000_0000;
            end
        endcase
        return word;
    endfunction

    // The checksum is kept as two byte registers; this joins them.
    assign sumNow = {s_q.sumHigh, s_q.sumLow};

    // A write is carried out in the cycle after both halves are held,
    // which keeps the byte fold off the bus input path.
    assign doWrite     = s_q.awHeld && s_q.wHeld;
    assign writeMapped = isMapped(s_q.awAddr);
    assign inWrite   = doWrite && s_q.wLane0 &&
                       (wordOf(s_q.awAddr) == crc16_checksum_pkg::OFFSET_BYTE_INPUT);
    assign lowWrite  = doWrite && s_q.wLane0 &&
                       (wordOf(s_q.awAddr) == crc16_checksum_pkg::OFFSET_SUM_LOW);
    assign highWrite = doWrite && s_q.wLane0 &&
                       (wordOf(s_q.awAddr) == crc16_checksum_pkg::OFFSET_SUM_HIGH);
    assign ctrlWrite = doWrite && s_q.wLane0 &&
                       (wordOf(s_q.awAddr) == crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL);
    assign readTaken = readReq.arvalid && s_q.arready;

    crc_byte_fold uFold (
        .sumIn      (sumNow),
        .dataByte   (s_q.wByte),
        .polySelect (s_q.polySelect),
        .sumOut     (foldOut)
    );

    // Next-state logic for the bus slave and the register file.
    always_comb begin
        s_d = s_q;

        // Write address is captured whenever it is offered and free.
        if (writeReq.awvalid && s_q.awready) begin
            s_d.awHeld = 1'b1;
            s_d.awAddr = writeReq.awaddr;
        end

        // Write data may arrive before, with or after the address.
        // Only the low lane matters, since every register is a byte.
        if (writeReq.wvalid && s_q.wready) begin
            s_d.wHeld  = 1'b1;
            s_d.wByte  = writeReq.wdata[7:0];
            s_d.wLane0 = writeReq.wstrb[0];
        end

        // Both halves held: apply the write and raise the response.
        if (doWrite) begin
            s_d.awHeld = 1'b0;
            s_d.wHeld  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = writeMapped ? crc16_checksum_pkg::RESP_OKAY
                                     : crc16_checksum_pkg::RESP_SLVERR;
        end

        if (inWrite) begin
            s_d.byteInput = s_q.wByte;
        end

        if (inWrite) begin
            s_d.sumHigh = foldOut[15:8];
            s_d.sumLow  = foldOut[7:0];
        end

        if (lowWrite) begin
            s_d.sumLow = s_q.wByte;
        end
        if (highWrite) begin
            s_d.sumHigh = s_q.wByte;
        end

        if (ctrlWrite) begin
            s_d.polySelect = s_q.wByte[crc16_checksum_pkg::POLYNOMIAL_SELECT_SELECT_BIT];
        end

        // The response drops once the master takes it.
        if (s_q.bvalid && writeReq.bready) begin
            s_d.bvalid = 1'b0;
        end

        // A new write is refused while a half is held or a response waits,
        // so at most one write is ever in flight.
        s_d.awready = !s_d.awHeld && !s_d.bvalid;
        s_d.wready  = !s_d.wHeld && !s_d.bvalid;

        // Read data is latched at the address handshake from the present
        // registers; a write applied in the same edge is not yet seen.
        if (readTaken) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = readWord(readReq.araddr, s_q);
            s_d.rresp  = isMapped(readReq.araddr) ? crc16_checksum_pkg::RESP_OKAY
                                                  : crc16_checksum_pkg::RESP_SLVERR;
        end
        if (s_q.rvalid && readReq.rready) begin
            s_d.rvalid = 1'b0;
        end

        // One read at a time: the address channel waits for the answer.
        s_d.arready = !s_d.rvalid;
    end

    // State register; reset loads constants only.
    // Keeping reset to constants avoids a reset path that depends on state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= crc16_checksum_pkg::UNIT_STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output is a field of the state register.
    assign writeRsp.awready = s_q.awready;
    assign writeRsp.wready  = s_q.wready;
    assign writeRsp.bvalid  = s_q.bvalid;
    assign writeRsp.bresp   = s_q.bresp;
    assign readRsp.arready  = s_q.arready;
    assign readRsp.rvalid   = s_q.rvalid;
    assign readRsp.rdata    = s_q.rdata;
    assign readRsp.rresp    = s_q.rresp;

    // Checks below share the one clock and reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Fixed example sums catch a wrong feedback term or byte position,
    // which a check against the design's own fold would never see.

    chk_input_latch: assert property (
        inWrite |=> s_q.byteInput == $past(s_q.wByte))
        else $error("Input register did not take the written byte.");

    chk_sum_source: assert property (
        (sumNow != $past(sumNow)) |-> $past(inWrite || lowWrite || highWrite))
        else $error("Checksum changed without a register write.");

    chk_sum_retain: assert property (
        !doWrite |=> $stable(sumNow))
        else $error("Checksum did not hold its previous result.");

    chk_high_read: assert property (
        (readTaken && wordOf(readReq.araddr) == crc16_checksum_pkg::OFFSET_SUM_HIGH)
        |=> s_q.rvalid && s_q.rdata == {24'h00_0000, $past(s_q.sumHigh)})
        else $error("High checksum read returned the wrong value.");

    chk_low_write: assert property (
        lowWrite |=> s_q.sumLow == $past(s_q.wByte))
        else $error("Low checksum write was not stored.");

    // single byte sums match both polynomials
    chk_polynomial_select_terms: assert property (
        (inWrite && sumNow == 16'h0000 && s_q.wByte == 8'h01)
        |=> sumNow == ($past(s_q.polySelect) ? 16'h8005 : 16'h1021))
        else $error("Polynomial select gave the wrong feedback.");

    chk_polynomial_select_store: assert property (
        ctrlWrite |=> s_q.polySelect == $past(s_q.wByte[0]))
        else $error("Polynomial select was not stored.");

    chk_ctrl_zero: assert property (
        (readTaken && wordOf(readReq.araddr) == crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL)
        |=> s_q.rdata[31:1] == 31'h0000_0000)
        else $error("Unimplemented control bits read non-zero.");

    chk_write_timing: assert property (
        (writeReq.awvalid && s_q.awready && writeReq.wvalid && s_q.wready)
        |=> doWrite ##1 s_q.bvalid)
        else $error("Write was not applied within one cycle.");

    chk_fold_value: assert property (
        (inWrite && sumNow == 16'h0000 && s_q.wByte == 8'h03 && s_q.polySelect)
        |=> sumNow == 16'h000A)
        else $error("Byte fold produced the wrong checksum.");

    chk_fold_apply: assert property (
        inWrite |=> sumNow == $past(foldOut))
        else $error("Input write did not load the folded sum.");

    chk_high_write: assert property (
        highWrite |=> s_q.sumHigh == $past(s_q.wByte))
        else $error("High checksum write was not stored.");

    chk_low_read: assert property (
        (readTaken && wordOf(readReq.araddr) == crc16_checksum_pkg::OFFSET_SUM_LOW)
        |=> s_q.rdata == {24'h00_0000, $past(s_q.sumLow)})
        else $error("Low checksum read returned the wrong value.");

    chk_input_read: assert property (
        (readTaken && wordOf(readReq.araddr) == crc16_checksum_pkg::OFFSET_BYTE_INPUT)
        |=> s_q.rdata == {24'h00_0000, $past(s_q.byteInput)})
        else $error("Input register read did not return the last byte.");

    chk_ctrl_read: assert property (
        (readTaken && wordOf(readReq.araddr) == crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL)
        |=> s_q.rdata[0] == $past(s_q.polySelect))
        else $error("Polynomial select read back wrong.");

    chk_ccitt_value: assert property (
        (inWrite && sumNow == 16'h0000 && s_q.wByte == 8'h03 && !s_q.polySelect)
        |=> sumNow == 16'h3063)
        else $error("CCITT byte fold produced the wrong checksum.");

    // next byte folds from stored sum
    chk_run_continue: assert property (
        (inWrite && sumNow == 16'hFF9F && s_q.wByte == 8'h56 && !s_q.polySelect)
        |=> sumNow == 16'hBBC3)
        else $error("Second byte did not fold from the stored sum.");

    chk_lane_blocked: assert property (
        (doWrite && !s_q.wLane0)
        |=> $stable(sumNow) && $stable(s_q.byteInput) && $stable(s_q.polySelect))
        else $error("Write with its byte lane off changed a register.");

    chk_unmapped_write: assert property (
        (doWrite && !writeMapped)
        |=> s_q.bresp == crc16_checksum_pkg::RESP_SLVERR && $stable(sumNow))
        else $error("Unmapped write was not refused.");

    chk_fold_answer: assert property (
        doWrite |=> s_q.bvalid)
        else $error("Write response did not follow the update.");

    chk_one_write: assert property (
        s_q.bvalid |-> !s_q.awready && !s_q.wready)
        else $error("New write accepted while a response waited.");

    // Main scenarios worth seeing.
    cov_ccitt_byte: cover property (inWrite && !s_q.polySelect);
    cov_crc16_byte: cover property (inWrite && s_q.polySelect);
    cov_bad_read: cover property (readTaken && !isMapped(readReq.araddr));
    cov_back_pressure: cover property (s_q.bvalid && !writeReq.bready);
    cov_unmapped_write: cover property (doWrite && !writeMapped);

endmodule

/* File: crc16_checksum_unit_bench.sv */
// Self-checking bench for the 16-bit checksum unit, driven over AXI4-Lite.
// Assumes the unit answers every request in bounded time; a watchdog ends a hang.
`timescale 1ns/10ps
module crc16_checksum_unit_bench;

    logic                               clock;       // Bench clock, 125 MHz.
    logic                               rst;         // Active-high reset.
    crc16_checksum_pkg::write_req_type  wreq;        // Write request to the unit.
    crc16_checksum_pkg::write_rsp_type  wrsp;        // Write answer from the unit.
    crc16_checksum_pkg::read_req_type   rreq;        // Read request to the unit.
    crc16_checksum_pkg::read_rsp_type   rrsp;        // Read answer from the unit.
    int                                 n_mismatch;  // Mismatches seen.
    int                                 n_checks;    // Comparisons made.
    logic [15:0]                        expSum;      // Expected checksum.

    // Single-byte results from a cleared sum, bytes 0 to 7.
    localparam logic [15:0] ONE_CCITT [8] = '{16'h0000, 16'h1021, 16'h2042, 16'h3063,
                                              16'h4084, 16'h50A5, 16'h60C6, 16'h70E7};
    localparam logic [15:0] ONE_CRC16 [8] = '{16'h0000, 16'h8005, 16'h800F, 16'h000A,
                                              16'h801B, 16'h001E, 16'h0014, 16'h8011};
    // Running results for the byte run 78, 56, 34, 12.
    localparam logic [7:0]  RUN_BYTES [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    localparam logic [15:0] RUN_CCITT [4] = '{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA};
    localparam logic [15:0] RUN_CRC16 [4] = '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43};

    crc16_checksum_unit crc16_checksum_unit_i (
        .clock    (clock),
        .rst      (rst),
        .writeReq (wreq),
        .writeRsp (wrsp),
        .readReq  (rreq),
        .readRsp  (rrsp)
    );

    // Free-running clock with an 8 ns period.
    always #4 clock = ~clock;

    // Bench reference of one byte fold, written apart from the design.
    function automatic logic [15:0] fold(input logic [15:0] s, input logic [7:0] b,
                                         input logic sel);
        logic [15:0] v;
        v = s ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            v = v[15] ? ((v << 1) ^ (sel ? 16'h8005 : 16'h1021)) : (v << 1);
        end
        return v;
    endfunction

    // Compares a data word and reports a mismatch at once.
    task automatic check_data(input string name, input logic [31:0] exp,
                              input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compares a bus response code.
    task automatic check_resp(input string name, input logic [1:0] exp,
                              input logic [1:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One AXI4-Lite write; address and data are offered together and each is
    // released at its own handshake edge, then the response is awaited.
    task automatic write_reg(input logic [7:0] addr, input logic [31:0] data,
                             input logic [3:0] strb, input logic [1:0] expResp);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone  = 1'b0;
        @(posedge clock);
        wreq.awvalid <= 1'b1;
        wreq.awaddr  <= addr;
        wreq.wvalid  <= 1'b1;
        wreq.wdata   <= data;
        wreq.wstrb   <= strb;
        wreq.bready  <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clock);
            if (!awDone && wrsp.awready === 1'b1) begin
                awDone = 1'b1;
                wreq.awvalid <= 1'b0;
            end
            if (!wDone && wrsp.wready === 1'b1) begin
                wDone = 1'b1;
                wreq.wvalid <= 1'b0;
            end
        end
        // Hold bready until the response is seen, then take the code.
        do @(posedge clock); while (wrsp.bvalid !== 1'b1);
        check_resp("write response", expResp, wrsp.bresp);
        wreq.bready <= 1'b0;
    endtask

    // One AXI4-Lite read with the data and response compared.
    task automatic read_check(input logic [7:0] addr, input logic [31:0] exp,
                              input logic [1:0] expResp);
        @(posedge clock);
        rreq.arvalid <= 1'b1;
        rreq.araddr  <= addr;
        rreq.rready  <= 1'b1;
        do @(posedge clock); while (rrsp.arready !== 1'b1);
        rreq.arvalid <= 1'b0;
        do @(posedge clock); while (rrsp.rvalid !== 1'b1);
        check_data("read data", exp, rrsp.rdata);
        check_resp("read response", expResp, rrsp.rresp);
        rreq.rready <= 1'b0;
    endtask

    // Clears both checksum registers, as software does before a run.
    task automatic clear_sum();
        write_reg(crc16_checksum_pkg::OFFSET_SUM_LOW, 32'h0, 4'h1, 2'h0);
        write_reg(crc16_checksum_pkg::OFFSET_SUM_HIGH, 32'h0, 4'h1, 2'h0);
    endtask

    // Reads both sum halves and compares them with one expected sum.
    task automatic check_sum(input logic [15:0] s);
        read_check(crc16_checksum_pkg::OFFSET_SUM_HIGH, {24'h0, s[15:8]}, 2'h0);
        read_check(crc16_checksum_pkg::OFFSET_SUM_LOW, {24'h0, s[7:0]}, 2'h0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog; the whole sequence needs well under a few thousand cycles.
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    // Main test sequence.
    initial begin
        clock      = 1'b0;
        rst        = 1'b1;
        wreq       = '0;
        rreq       = '0;
        n_mismatch = 0;
        n_checks   = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        // Every register comes out of reset cleared; unmapped space is refused.
        read_check(crc16_checksum_pkg::OFFSET_BYTE_INPUT, 32'h0, 2'h0);
        check_sum(16'h0000);
        read_check(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'h0, 2'h0);
        read_check(8'h10, 32'h0, 2'h2);
        // Only the select bit of the control word is kept.
        write_reg(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'hFFFFFFFF, 4'h1, 2'h0);
        read_check(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'h1, 2'h0);
        write_reg(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'h000000FE, 4'h1, 2'h0);
        read_check(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'h0, 2'h0);
        // Single bytes from a cleared sum under both generators.
        for (int s = 0; s < 2; s++) begin
            for (int b = 0; b < 8; b++) begin
                clear_sum();
                write_reg(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'(s), 4'h1, 2'h0);
                write_reg(crc16_checksum_pkg::OFFSET_BYTE_INPUT, 32'(b), 4'h1, 2'h0);
                check_sum((s == 1) ? ONE_CRC16[b] : ONE_CCITT[b]);
                read_check(crc16_checksum_pkg::OFFSET_BYTE_INPUT, 32'(b), 2'h0);
            end
        end
        // A byte run where each fold starts from the stored result.
        for (int s = 0; s < 2; s++) begin
            clear_sum();
            write_reg(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'(s), 4'h1, 2'h0);
            for (int i = 0; i < 4; i++) begin
                write_reg(crc16_checksum_pkg::OFFSET_BYTE_INPUT, {24'h0, RUN_BYTES[i]},
                          4'h1, 2'h0);
                check_sum((s == 1) ? RUN_CRC16[i] : RUN_CCITT[i]);
            end
        end
        // Sum halves are writable; upper data bits and low address bits are dropped.
        write_reg(crc16_checksum_pkg::OFFSET_SUM_HIGH, 32'h000012A5, 4'h1, 2'h0);
        write_reg(crc16_checksum_pkg::OFFSET_SUM_LOW, 32'hFFFF005A, 4'h1, 2'h0);
        read_check(8'h05, 32'h0000005A, 2'h0);
        check_sum(16'hA55A);
        // A fold from a software-written, non-zero start value.
        expSum = fold(16'hA55A, 8'h3C, 1'b1);
        write_reg(crc16_checksum_pkg::OFFSET_POLYNOMIAL_SELECT_CONTROL, 32'h1, 4'h1, 2'h0);
        write_reg(crc16_checksum_pkg::OFFSET_BYTE_INPUT, 32'h3C, 4'h1, 2'h0);
        check_sum(expSum);
        // A write with its byte lane off changes nothing.
        write_reg(crc16_checksum_pkg::OFFSET_BYTE_INPUT, 32'h77, 4'h0, 2'h0);
        read_check(crc16_checksum_pkg::OFFSET_BYTE_INPUT, 32'h3C, 2'h0);
        check_sum(expSum);
        // A write to unmapped space is refused and folds nothing.
        write_reg(8'h20, 32'h55, 4'h1, 2'h2);
        check_sum(expSum);
        final_report();
    end

endmodule
